// [core/lpoc_params.svh]
// Constants of the LVDS pixel output control block: register map, fields, resets and timing.
// Assumes inclusion by bare name from the package and the core module only.
`ifndef LPOC_PARAMS_SVH
`define LPOC_PARAMS_SVH

// Register offsets on the plain register port.
`define LPOC_REG_CONTROL 4'h0
`define LPOC_REG_MODE 4'h1
`define LPOC_REG_STATUS 4'h2
`define LPOC_REG_STRAP 4'h3

// Control register fields.
`define LPOC_CTL_OEN_BIT 0
`define LPOC_CTL_OSS_BIT 1
`define LPOC_CTL_MAP_BIT 2
`define LPOC_CTL_LFM_BIT 3
`define LPOC_CTL_D18_BIT 4
`define LPOC_CTL_OSC_BIT 5
`define LPOC_CTL_RESET 8'h00

// Mode register fields: code in the low nibble, override enable on top.
`define LPOC_MODE_OVR_BIT 7
`define LPOC_MODE_RESET 8'h01

// Configuration codes of the strap.
`define LPOC_MODE_FIRST 4'h1
`define LPOC_MODE_LEGACY 4'h9

// Clock lane pattern per frame, bit 0 leaves first: two high, three low, two high.
`define LPOC_CLK_PATTERN 7'h63
`define LPOC_BITS_PER_LANE 7

// Timing at the 100 ns system clock.
`define LPOC_CLK_NS 100
`define LPOC_LOCK_SETTLE_NS 2000
`define LPOC_LOCK_SETTLE_CYC ((`LPOC_LOCK_SETTLE_NS + `LPOC_CLK_NS - 1) / `LPOC_CLK_NS)
`define LPOC_OSC_HALF_NS 400
`define LPOC_OSC_HALF_CYC (`LPOC_OSC_HALF_NS / `LPOC_CLK_NS)

// Cipher seed held only inside the block; the value is arbitrary.
`define LPOC_KEY_SEED 24'h5a3c91

`endif

// [core/lpoc_pkg.sv]
// Types shared by the LVDS pixel output control block.
// Assumes lpoc_params.svh is on the include path.
package lpoc_pkg;
    `include "lpoc_params.svh"

    // Link state, one-hot.
    typedef enum logic [2:0] {
        LPOC_DOWN    = 3'b001,
        LPOC_ACQUIRE = 3'b010,
        LPOC_LOCKED  = 3'b100
    } lpoc_state_t;

    typedef logic [3:0] lpoc_code_t;
    typedef logic [7:0] lpoc_byte_t;
endpackage : lpoc_pkg

// [core/lpoc_output_control.sv]
// Output stage and mode control of a video deserializer: frames recovered pixels onto four LVDS
// data lanes and one LVDS clock lane, drives lock and link-check pins, decodes the mode strap.
// Assumes clk at 10 MHz, synchronous active-high rst, and all pin inputs asynchronous to clk.
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "lpoc_params.svh"

module lpoc_output_control
    import lpoc_pkg::*;
#(
    parameter int LOCK_SETTLE_CYC = `LPOC_LOCK_SETTLE_CYC,
    parameter int OSC_HALF_CYC = `LPOC_OSC_HALF_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire lpoc_pkg::lpoc_code_t reg_addr,
    input wire lpoc_pkg::lpoc_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output lpoc_pkg::lpoc_byte_t reg_rdata,
    // Pins from the link front end and the board.
    input wire logic powerdown_release,
    input wire logic serial_active,
    input wire logic cdr_lock,
    input wire logic pixel_clock,
    input wire lpoc_pkg::lpoc_byte_t pix_red,
    input wire lpoc_pkg::lpoc_byte_t pix_green,
    input wire lpoc_pkg::lpoc_byte_t pix_blue,
    input wire logic pix_hsync,
    input wire logic pix_vsync,
    input wire logic pix_de,
    input wire logic audio_in,
    input wire logic audio_island,
    input wire logic protect_active,
    // Strap pins.
    input wire logic output_drive_enable_pin,
    input wire logic sleep_state_select_pin,
    input wire logic color_map_select_pin,
    input wire logic low_rate_mode_pin,
    input wire lpoc_pkg::lpoc_code_t mode_strap,
    // Parallel status and audio outputs with enables.
    output logic lock_out,
    output logic lock_oe,
    output logic link_check_out,
    output logic link_check_oe,
    output logic audio_out,
    output logic audio_oe,
    // LVDS lanes.
    output logic [3:0] lvds_data_lane,
    output logic lvds_clock_lane,
    output logic lvds_oe,
    // Mode outputs.
    output logic relay_mode,
    output logic legacy_compat,
    output logic audio_set_b,
    output logic long_cable_eq,
    output logic line_rate_x4
);
    import lpoc_pkg::*;

    localparam int SYNC_W = 42;
    localparam logic [23:0] KEY_SEED = `LPOC_KEY_SEED;

    // Decodes a strap code into relay, legacy, second audio set and cable equalizer bits.
    function automatic logic [3:0] decode_mode(input lpoc_code_t code);
        logic [3:0] m;
        lpoc_code_t k;
        m = 4'h0;
        k = code - 4'h1;
        if (code == `LPOC_MODE_LEGACY) begin
            m = 4'b0100;
        end else if (code >= `LPOC_MODE_FIRST && code < `LPOC_MODE_LEGACY) begin
            m = {k[1], 1'b0, k[0], k[2]}; // Relay, legacy off, second audio set, cable equalizer.
        end
        return m;
    endfunction : decode_mode

    // Builds one 28-bit frame, lane n in bits 7n+6..7n, bit 0 of each lane first on the wire.
    function automatic logic [27:0] build_frame(input lpoc_byte_t r, input lpoc_byte_t g,
        input lpoc_byte_t b, input logic hs, input logic vs, input logic de, input logic aud,
        input logic msb_l3, input logic d18);
        logic [5:0] sr, sg, sb;
        logic [1:0] tr, tg, tb;
        logic [6:0] l3;
        sr = (msb_l3 && !d18) ? r[5:0] : r[7:2];
        sg = (msb_l3 && !d18) ? g[5:0] : g[7:2];
        sb = (msb_l3 && !d18) ? b[5:0] : b[7:2];
        tr = msb_l3 ? r[7:6] : r[1:0];
        tg = msb_l3 ? g[7:6] : g[1:0];
        tb = msb_l3 ? b[7:6] : b[1:0];
        l3 = d18 ? 7'h00 : {aud, tb, tg, tr};
        return {l3, de, vs, hs, sb[5:2], sb[1:0], sg[5:1], sg[0], sr};
    endfunction : build_frame

    // Two-flop synchronisers for every pin input; stage one feeds only stage two.
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic pclk_prev;
    logic pdb_prev;
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
            pclk_prev <= 1'b0;
            pdb_prev <= 1'b0;
        end else begin
            sync_a <= {powerdown_release, serial_active, cdr_lock, pixel_clock, pix_red, pix_green,
                       pix_blue, pix_hsync, pix_vsync, pix_de, audio_in, audio_island, protect_active,
                       output_drive_enable_pin, sleep_state_select_pin, color_map_select_pin,
                       low_rate_mode_pin, mode_strap};
            sync_b <= sync_a;
            pclk_prev <= sync_b[38];
            pdb_prev <= sync_b[41];
        end
    end

    logic pdb_s, act_s, cdr_s, pclk_s, hs_s, vs_s, de_s, aud_s, isl_s, prot_s;
    logic oen_p, oss_p, map_p, lfm_p;
    lpoc_byte_t r_s, g_s, b_s;
    lpoc_code_t strap_s;
    assign {pdb_s, act_s, cdr_s, pclk_s, r_s, g_s, b_s, hs_s, vs_s, de_s, aud_s, isl_s, prot_s,
            oen_p, oss_p, map_p, lfm_p, strap_s} = sync_b;
    wire pdb_rise = pdb_s && !pdb_prev;
    wire pclk_rise = pclk_s && !pclk_prev;

    // Link state: lock is granted only after a stable recovery interval.
    lpoc_state_t state;
    logic [15:0] settle_cnt;
    always_ff @(posedge clk) begin
        if (rst || !pdb_s) begin
            state <= LPOC_DOWN;
            settle_cnt <= 16'h0000;
        end else begin
            unique case (state)
                LPOC_DOWN: begin
                    state <= LPOC_ACQUIRE;
                    settle_cnt <= 16'h0000;
                end
                LPOC_ACQUIRE: begin
                    if (!(act_s && cdr_s)) begin
                        settle_cnt <= 16'h0000;
                    end else if (settle_cnt == 16'(LOCK_SETTLE_CYC - 1)) begin
                        state <= LPOC_LOCKED;
                    end else begin
                        settle_cnt <= settle_cnt + 16'h0001;
                    end
                end
                LPOC_LOCKED: begin
                    if (!(act_s && cdr_s)) begin
                        state <= LPOC_ACQUIRE;
                        settle_cnt <= 16'h0000;
                    end
                end
            endcase
        end
    end
    wire locked = (state == LPOC_LOCKED);
    logic locked_prev;
    always_ff @(posedge clk) begin
        if (rst) begin
            locked_prev <= 1'b0;
        end else begin
            locked_prev <= locked;
        end
    end
    wire lock_lost = locked_prev && !locked;

    // Control register: straps load at power-down release, writes override at once.
    lpoc_byte_t ctrl;
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= `LPOC_CTL_RESET;
        end else if (reg_wr && reg_addr == `LPOC_REG_CONTROL) begin
            ctrl <= reg_wdata; // set wins over the self-clear below
        end else begin
            if (pdb_rise) begin
                ctrl[`LPOC_CTL_OEN_BIT] <= oen_p;
                ctrl[`LPOC_CTL_OSS_BIT] <= oss_p;
                ctrl[`LPOC_CTL_MAP_BIT] <= map_p;
                ctrl[`LPOC_CTL_LFM_BIT] <= lfm_p;
            end else if (lock_lost) begin
                ctrl[`LPOC_CTL_OEN_BIT] <= 1'b0;
            end
        end
    end
    wire output_drive_enable = ctrl[`LPOC_CTL_OEN_BIT];
    wire oss = ctrl[`LPOC_CTL_OSS_BIT];
    wire msb_l3 = ctrl[`LPOC_CTL_MAP_BIT];
    wire d18 = ctrl[`LPOC_CTL_D18_BIT];
    wire osc_en = ctrl[`LPOC_CTL_OSC_BIT];

    // Mode register and strap latch.
    lpoc_byte_t mode_reg;
    lpoc_code_t strap_latch;
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= `LPOC_MODE_RESET;
            strap_latch <= `LPOC_MODE_FIRST;
        end else begin
            if (reg_wr && reg_addr == `LPOC_REG_MODE) begin
                mode_reg <= reg_wdata;
            end
            if (pdb_rise) begin
                strap_latch <= strap_s;
            end
        end
    end
    wire [3:0] mode_bits = decode_mode(mode_reg[`LPOC_MODE_OVR_BIT] ? mode_reg[3:0] : strap_latch);

    // Mode outputs and the line-rate ratio.
    always_ff @(posedge clk) begin
        if (rst) begin
            relay_mode <= 1'b0;
            legacy_compat <= 1'b0;
            audio_set_b <= 1'b0;
            long_cable_eq <= 1'b0;
            line_rate_x4 <= 1'b0;
        end else begin
            {relay_mode, legacy_compat, audio_set_b, long_cable_eq} <= mode_bits;
            line_rate_x4 <= ctrl[`LPOC_CTL_LFM_BIT] && !mode_bits[2];
        end
    end

    // Keystream generator: the seed stays internal and has no read path.
    logic [23:0] keystream;
    always_ff @(posedge clk) begin
        if (rst || !prot_s) begin
            keystream <= KEY_SEED;
        end else if (pclk_rise) begin
            keystream <= {keystream[22:0], keystream[23] ^ keystream[22] ^ keystream[21] ^ keystream[16]};
        end
    end
    wire [23:0] plain = {r_s, g_s, b_s} ^ (prot_s ? keystream : 24'h000000);
    wire aud_plain = (isl_s && prot_s) ? (aud_s ^ keystream[0]) : aud_s;

    // Frame shifter: loads one pixel per pixel clock rise and sends seven bit periods per lane.
    logic [27:0] frame;
    logic [6:0] clk_pat;
    logic [2:0] bit_cnt;
    always_ff @(posedge clk) begin
        if (rst || !locked) begin
            frame <= 28'h0000000;
            clk_pat <= 7'h00;
            bit_cnt <= 3'h0;
        end else if (pclk_rise) begin
            frame <= build_frame(plain[23:16], plain[15:8], plain[7:0], hs_s, vs_s, de_s, aud_plain,
                                 msb_l3, d18);
            clk_pat <= `LPOC_CLK_PATTERN;
            bit_cnt <= 3'h0;
        end else if (bit_cnt != 3'(`LPOC_BITS_PER_LANE - 1)) begin
            frame <= {1'b0, frame[27:22], 1'b0, frame[20:15], 1'b0, frame[13:8], 1'b0, frame[6:1]};
            clk_pat <= {1'b0, clk_pat[6:1]};
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    // Free-running oscillator for the clock lane while idle.
    logic osc;
    logic [7:0] osc_cnt;
    always_ff @(posedge clk) begin
        if (rst || !osc_en) begin
            osc <= 1'b0;
            osc_cnt <= 8'h00;
        end else if (osc_cnt == 8'(OSC_HALF_CYC - 1)) begin
            osc <= !osc;
            osc_cnt <= 8'h00;
        end else begin
            osc_cnt <= osc_cnt + 8'h01;
        end
    end

    // Output state table.
    always_ff @(posedge clk) begin
        if (rst || !pdb_s) begin
            {lock_out, lock_oe, link_check_out, link_check_oe, audio_out, audio_oe} <= 6'h00;
            lvds_data_lane <= 4'h0;
            lvds_clock_lane <= 1'b0;
            lvds_oe <= 1'b0;
        end else if (!output_drive_enable) begin
            lock_out <= locked;
            lock_oe <= 1'b1;
            {link_check_out, audio_out, lvds_clock_lane} <= 3'h0;
            lvds_data_lane <= 4'h0;
            {link_check_oe, audio_oe, lvds_oe} <= {3{!oss}};
        end else begin
            {lock_oe, link_check_oe, audio_oe, lvds_oe} <= 4'hf;
            if (oss && locked) begin
                lock_out <= 1'b1;
                link_check_out <= 1'b1;
                audio_out <= aud_plain;
                lvds_data_lane <= {frame[21], frame[14], frame[7], frame[0]};
                lvds_clock_lane <= clk_pat[0];
            end else begin
                lock_out <= 1'b0;
                if (!oss || act_s) begin
                    link_check_out <= 1'b0;
                end else begin
                    link_check_out <= link_check_out;
                end
                audio_out <= 1'b0;
                lvds_data_lane <= 4'h0;
                lvds_clock_lane <= (!oss && !act_s && osc_en) ? osc : 1'b0;
            end
        end
    end

    // Register read port: data stands only in the cycle after the read strobe.
    always_ff @(posedge clk) begin
        if (rst || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                `LPOC_REG_CONTROL: reg_rdata <= ctrl;
                `LPOC_REG_MODE: reg_rdata <= mode_reg;
                `LPOC_REG_STATUS: reg_rdata <= {line_rate_x4, relay_mode, legacy_compat, audio_set_b,
                                                long_cable_eq, act_s, link_check_out, locked};
                `LPOC_REG_STRAP: reg_rdata <= {4'h0, strap_latch};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule : lpoc_output_control

// [testbench/lpoc_output_control_asserts.sv]
// Checker of the LVDS pixel output control block, bound to its top module.
// Assumes only the top module's ports, one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module lpoc_output_control_asserts
    import lpoc_pkg::*;
#(
    parameter int LOCK_SETTLE_CYC = 20
) (
    // Clock, reset and watched inputs.
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic serial_active,
    input wire logic cdr_lock,
    // Watched outputs.
    input wire lpoc_pkg::lpoc_byte_t reg_rdata,
    input wire logic lock_out,
    input wire logic [3:0] lvds_data_lane,
    input wire logic lvds_clock_lane,
    input wire logic lvds_oe,
    input wire logic relay_mode,
    input wire logic legacy_compat,
    input wire logic audio_set_b,
    input wire logic long_cable_eq,
    input wire logic line_rate_x4
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Counts cycles of unbroken lock from the front end, so early lock claims show up.
    logic [7:0] settle_cnt;
    always_ff @(posedge clk) begin
        if (rst || !(cdr_lock && serial_active)) begin
            settle_cnt <= 8'h00;
        end else if (settle_cnt != 8'hff) begin
            settle_cnt <= settle_cnt + 8'h01;
        end
    end

    property p_rdata_quiet;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside its cycle");
    property p_lanes_need_lock;
        lvds_data_lane != 4'h0 |-> lock_out || $past(lock_out);
    endproperty
    a_lanes_need_lock: assert property (p_lanes_need_lock) else $error("lanes busy without lock");
    property p_lanes_drive;
        lvds_data_lane != 4'h0 |-> lvds_oe;
    endproperty
    a_lanes_drive: assert property (p_lanes_drive) else $error("lanes busy while not driven");
    property p_clock_low_run;
        $fell(lvds_clock_lane) && lock_out |->
            ##1 (!lvds_clock_lane || !lock_out) [*2] ##1 (lvds_clock_lane || !lock_out);
    endproperty
    a_clock_low_run: assert property (p_clock_low_run) else $error("clock lane low run not three");
    property p_clock_high_run;
        $rose(lvds_clock_lane) && lock_out |-> ##1 (lvds_clock_lane || !lock_out);
    endproperty
    a_clock_high_run: assert property (p_clock_high_run) else $error("clock lane high run too short");
    property p_legacy_only;
        legacy_compat |-> !relay_mode && !audio_set_b && !long_cable_eq;
    endproperty
    a_legacy_only: assert property (p_legacy_only) else $error("legacy mode with other mode bits");
    property p_legacy_rate;
        legacy_compat |-> !line_rate_x4;
    endproperty
    a_legacy_rate: assert property (p_legacy_rate) else $error("line rate raised in legacy mode");
    property p_lock_settle;
        $rose(lock_out) |-> int'(settle_cnt) >= LOCK_SETTLE_CYC;
    endproperty
    a_lock_settle: assert property (p_lock_settle) else $error("lock shown before recovery settled");
    property p_idle_unlock;
        !serial_active [*6] |-> !lock_out;
    endproperty
    a_idle_unlock: assert property (p_idle_unlock) else $error("lock held with no serial input");

    // Main scenarios reached by the bench.
    c_lock: cover property ($rose(lock_out));
    c_frame: cover property ($fell(lvds_clock_lane) && lock_out);
    c_legacy: cover property (legacy_compat);
    c_rate_x4: cover property (line_rate_x4);
endmodule : lpoc_output_control_asserts

bind lpoc_output_control lpoc_output_control_asserts #(
    .LOCK_SETTLE_CYC(LOCK_SETTLE_CYC)
) lpoc_output_control_asserts_i (
    .clk, .rst, .reg_rd, .serial_active, .cdr_lock, .reg_rdata, .lock_out, .lvds_data_lane,
    .lvds_clock_lane, .lvds_oe, .relay_mode, .legacy_compat, .audio_set_b, .long_cable_eq, .line_rate_x4
);

// [testbench/lpoc_lvds_sink.sv]
// Panel-side model of the LVDS lanes: rebuilds every seven-bit frame and counts frames.
// Assumes one lane bit per clk and a frame that starts two bits before the clock lane falls.
// The panel applies no white balance or dithering to what it receives.
`timescale 1ns/1ns
module lpoc_lvds_sink (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Lanes from the block.
    input wire logic [3:0] lvds_data_lane,
    input wire logic lvds_clock_lane,
    // Rebuilt frame, lane l at bits 7*l, first bit sent lowest.
    output logic [27:0] frame,
    output logic [6:0] clock_frame,
    output logic [15:0] frame_count
);
    logic [27:0] shift_lanes;
    logic [6:0] shift_clock;
    logic [2:0] phase;
    logic last_clock;

    // Shifts all lanes in and grabs a whole frame at its seventh bit.
    always_ff @(posedge clk) begin
        last_clock <= lvds_clock_lane;
        shift_clock <= {lvds_clock_lane, shift_clock[6:1]};
        for (int l = 0; l < 4; l++) begin
            shift_lanes[7*l +: 7] <= {lvds_data_lane[l], shift_lanes[7*l+1 +: 6]};
        end
        if (rst) begin
            phase <= 3'h0;
            frame_count <= 16'h0000;
        end else begin
            if (last_clock && !lvds_clock_lane) begin
                phase <= 3'h1;
            end else if (phase == 3'h4) begin
                phase <= 3'h0;
            end else if (phase != 3'h0) begin
                phase <= phase + 3'h1;
            end
            if (phase == 3'h4) begin
                frame_count <= frame_count + 16'h0001;
                clock_frame <= {lvds_clock_lane, shift_clock[6:1]};
                for (int l = 0; l < 4; l++) begin
                    frame[7*l +: 7] <= {lvds_data_lane[l], shift_lanes[7*l+1 +: 6]};
                end
            end
        end
    end
endmodule : lpoc_lvds_sink

// [testbench/tb_top.sv]
// Self-checking bench of the LVDS pixel output control block with a panel-side lane model.
// Assumes a 10 MHz clk, an 800 ns pixel clock unrelated in phase, and a short lock settle count.
`timescale 1ns/1ns
module tb_top;
    import lpoc_pkg::*;
    localparam int SETTLE = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    lpoc_code_t reg_addr = 4'h0;
    lpoc_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic powerdown_release = 1'b0;
    logic serial_active = 1'b0;
    logic cdr_lock = 1'b0;
    logic pixel_clock = 1'b0;
    logic pix_run = 1'b0;
    lpoc_byte_t pix_red = 8'hb5;
    lpoc_byte_t pix_green = 8'h05;
    lpoc_byte_t pix_blue = 8'h3c;
    logic pix_hsync = 1'b1;
    logic pix_vsync = 1'b0;
    logic pix_de = 1'b1;
    logic audio_in = 1'b0;
    logic audio_island = 1'b0;
    logic protect_active = 1'b0;
    logic output_drive_enable_pin = 1'b1;
    logic sleep_state_select_pin = 1'b1;
    logic color_map_select_pin = 1'b0;
    logic low_rate_mode_pin = 1'b0;
    lpoc_code_t mode_strap = 4'h1;
    lpoc_byte_t reg_rdata;
    logic lock_out, lock_oe, link_check_out, link_check_oe, audio_out, audio_oe;
    logic [3:0] lvds_data_lane;
    logic lvds_clock_lane, lvds_oe, relay_mode, legacy_compat, audio_set_b, long_cable_eq, line_rate_x4;
    logic [27:0] frame;
    logic [6:0] clock_frame;
    logic [15:0] frame_count;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;

    lpoc_output_control #(.LOCK_SETTLE_CYC(SETTLE), .OSC_HALF_CYC(1)) lpoc_output_control_i (
        .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .powerdown_release, .serial_active,
        .cdr_lock, .pixel_clock, .pix_red, .pix_green, .pix_blue, .pix_hsync, .pix_vsync, .pix_de, .audio_in,
        .audio_island, .protect_active, .output_drive_enable_pin, .sleep_state_select_pin, .color_map_select_pin,
        .low_rate_mode_pin, .mode_strap, .lock_out, .lock_oe, .link_check_out, .link_check_oe, .audio_out,
        .audio_oe, .lvds_data_lane, .lvds_clock_lane, .lvds_oe, .relay_mode, .legacy_compat, .audio_set_b,
        .long_cable_eq, .line_rate_x4
    );
    lpoc_lvds_sink lpoc_lvds_sink_i (.clk, .rst, .lvds_data_lane, .lvds_clock_lane, .frame, .clock_frame,
        .frame_count);

    // System clock, and a pixel clock that runs only while frames are wanted.
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        #137;
        forever #400 pixel_clock = pix_run ? ~pixel_clock : 1'b0;
    end

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic reg_write(input lpoc_code_t a, input lpoc_byte_t d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input lpoc_code_t a, output lpoc_byte_t d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : reg_read
    // Pulses the power-down pin so straps are taken again.
    task automatic release_link();
        @(posedge clk);
        powerdown_release <= 1'b0;
        repeat (4) @(posedge clk);
        powerdown_release <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : release_link
    task automatic tally_and_finish();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Reset values, an unmapped read and the straps taken at release.
    task automatic test_reset_values();
        lpoc_byte_t d;
        reg_read(4'h1, d);
        chk(d, 8'h01);
        reg_read(4'h7, d);
        chk(d, 8'h00);
        reg_read(4'h0, d);
        chk(d, 8'h03);
    endtask : test_reset_values
    // Strap codes 1 to 9 with low-rate mode on, each after a power-down cycle.
    task automatic test_strap_modes();
        lpoc_byte_t d;
        logic [3:0] m;
        logic [4:0] exp;
        low_rate_mode_pin <= 1'b1;
        for (int c = 1; c <= 9; c++) begin
            mode_strap <= 4'(c);
            release_link();
            m = 4'(c - 1);
            exp = (c == 9) ? 5'b00100 : {1'b1, m[1], 1'b0, m[0], m[2]};
            reg_read(4'h2, d);
            chk(d[7:3], exp);
            chk({line_rate_x4, relay_mode, legacy_compat, audio_set_b, long_cable_eq}, exp);
        end
        low_rate_mode_pin <= 1'b0;
        mode_strap <= 4'h1;
        release_link();
    endtask : test_strap_modes
    // Register override of the mode code takes effect at once.
    task automatic test_mode_override();
        lpoc_byte_t d;
        reg_write(4'h1, 8'h89);
        reg_read(4'h2, d);
        chk(d[6:3], 4'b0100);
        reg_write(4'h1, 8'h84);
        reg_read(4'h2, d);
        chk(d[6:3], 4'b1010);
        reg_write(4'h1, 8'h01);
    endtask : test_mode_override
    // Locks, then checks frames in both maps and in 18-bit color.
    task automatic test_frames();
        lpoc_byte_t d;
        logic [15:0] n0;
        serial_active <= 1'b1;
        cdr_lock <= 1'b1;
        pix_run <= 1'b1;
        for (int i = 0; i < 200 && lock_out !== 1'b1; i++) @(posedge clk);
        chk({lock_out, lock_oe, lvds_oe}, 3'b111);
        reg_read(4'h2, d);
        chk(d[0], 1'b1);
        reg_write(4'h0, 8'h07);
        repeat (40) @(posedge clk);
        chk(frame[6:0], {pix_green[0], pix_red[5:0]});
        chk(frame[20:18], {pix_de, pix_vsync, pix_hsync});
        chk(clock_frame, 7'h63);
        n0 = frame_count;
        repeat (80) @(posedge clk);
        chk(frame_count - n0, 16'd10);
        reg_write(4'h0, 8'h03);
        repeat (40) @(posedge clk);
        chk(frame[6:0], {pix_green[2], pix_red[7:2]});
        reg_write(4'h0, 8'h13);
        repeat (40) @(posedge clk);
        chk(frame[27:21], 7'h00);
        protect_active <= 1'b1;
        audio_in <= 1'b1;
        repeat (6) @(posedge clk);
        chk({audio_out, audio_oe, link_check_oe}, 3'b111);
        protect_active <= 1'b0;
    endtask : test_frames
    // Loses the serial input, then checks idle states and the idle oscillator.
    task automatic test_lock_loss();
        lpoc_byte_t d;
        logic seen_hi, seen_lo;
        serial_active <= 1'b0;
        repeat (12) @(posedge clk);
        chk({lock_out, lvds_data_lane, lvds_clock_lane}, 6'h00);
        reg_read(4'h0, d);
        chk(d[0], 1'b0);
        reg_write(4'h0, 8'h01);
        repeat (6) @(posedge clk);
        chk({lock_out, link_check_out, lvds_data_lane}, 6'h00);
        reg_write(4'h0, 8'h21);
        seen_hi = 1'b0;
        seen_lo = 1'b0;
        repeat (4) @(posedge clk);
        repeat (10) begin
            @(posedge clk);
            seen_hi |= (lvds_clock_lane === 1'b1);
            seen_lo |= (lvds_clock_lane === 1'b0);
        end
        chk({seen_hi, seen_lo}, 2'b11);
    endtask : test_lock_loss

    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        powerdown_release <= 1'b1;
        repeat (8) @(posedge clk);
        test_reset_values();
        test_strap_modes();
        test_mode_override();
        test_frames();
        test_lock_loss();
        tally_and_finish();
    end
endmodule : tb_top
